// *** rtl/tas_pkg.sv ***
// constants and carrier types for the tilt sensor readout
//
// What this block does
// - the serial slave port answers only to seven-bit address 0x55
// - enable high keeps the whole sensing system switched on
// - enable low keeps the sensing system switched off
// - three tilt outputs exist, one each for X, Y and Z
// - a tilt output goes high when its axis exceeds 0.688 g
// - a tilt output goes low when its axis is at or below 0.688 g
// - tilt outputs are push-pull, driven both high and low
// - data line is driven only low; pull-up gives high; clock is an input only
// - each axis sample is 14 bits, 1 mg per count, plus or minus 8 g
// - each enable rising edge takes one sample per axis, offset and gain corrected
// - absolute value of each sample is compared against the threshold
// - register zero reports data ready; master reads it before samples
// - enable low puts the tilt outputs and serial data in high impedance; sensing_on is driven low
package tas_pkg;

   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   localparam logic [6:0] TAS_SLAVE_ADDR = 7'h55;
   localparam logic [7:0] TAS_REG_STATUS = 8'h00;
   localparam logic [7:0] TAS_REG_X_MSB = 8'h01;
   localparam logic [7:0] TAS_REG_X_LSB = 8'h02;
   localparam logic [7:0] TAS_REG_Y_MSB = 8'h03;
   localparam logic [7:0] TAS_REG_Y_LSB = 8'h04;
   localparam logic [7:0] TAS_REG_Z_MSB = 8'h05;
   localparam logic [7:0] TAS_REG_Z_LSB = 8'h06;
   localparam int TAS_STAT_ALL_BIT = 3;

   // ------------------------------------------------------------
   // samples and threshold
   // ------------------------------------------------------------
   localparam int TAS_SAMPLE_W = 14;
   localparam int TAS_AXES = 3;
   localparam logic [14:0] TAS_TILT_LIMIT = 15'h02B0;
   localparam logic signed [31:0] TAS_SAT_MAX = 32'sh00001FFF;
   localparam logic signed [31:0] TAS_SAT_MIN = -32'sh00002000;
   localparam logic [11:0] TAS_GAIN_UNITY = 12'h400;
   localparam int TAS_GAIN_SHIFT = 10;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int TAS_CLK_HZ = 20_000_000;
   localparam int TAS_CONV_US = 700;
   localparam int TAS_CONV_CYCLES = TAS_CONV_US * (TAS_CLK_HZ / 1_000_000);
   localparam int TAS_CNT_W = 24;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [TAS_AXES-1:0][TAS_SAMPLE_W-1:0] axis;
   } tas_axes_type;

   typedef struct packed {
      logic [TAS_AXES-1:0] level;
      logic [TAS_AXES-1:0] oe;
   } tas_tilt_type;

   typedef enum logic [1:0] {
      TAS_PWR_OFF = 2'b00,
      TAS_PWR_ACTIVE = 2'b01,
      TAS_PWR_STANDBY = 2'b10
   } tas_pwr_type;

   typedef enum logic [2:0] {
      TAS_I2C_IDLE = 3'b000,
      TAS_I2C_ADDR = 3'b001,
      TAS_I2C_ADDR_ACK = 3'b010,
      TAS_I2C_PTR = 3'b011,
      TAS_I2C_PTR_ACK = 3'b100,
      TAS_I2C_TX = 3'b101,
      TAS_I2C_TX_ACK = 3'b110,
      TAS_I2C_TX_NEXT = 3'b111
   } tas_i2c_type;

endpackage

// *** rtl/tas_sensor_readout.sv ***
// tilt sensor digital readout: power sequencing, tilt outputs, serial slave
`timescale 1ns/1ps
module tas_sensor_readout #(
   parameter int CONV_CYCLES = tas_pkg::TAS_CONV_CYCLES,
   parameter logic [2:0][13:0] OFFSET = '0,
   parameter logic [2:0][11:0] GAIN = {3{tas_pkg::TAS_GAIN_UNITY}}
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // power control
   input wire logic en,
   output logic sensing_on,
   // raw samples from the front end
   input wire tas_pkg::tas_axes_type raw_accel,
   // tilt pins
   output tas_pkg::tas_tilt_type tilt,
   // serial bus, open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   import tas_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_q;
   logic rst_n;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // ------------------------------------------------------------
   // per-axis correction and threshold
   // ------------------------------------------------------------
   tas_axes_type raw_hold;
   tas_axes_type sample;
   tas_axes_type corr;
   logic [2:0] hit;

   for (genvar i = 0; i < TAS_AXES; i++) begin : g_axis
      logic signed [31:0] diff;
      logic signed [31:0] scaled;
      logic [14:0] mag;
      assign diff = 32'(signed'(raw_hold.axis[i])) - 32'(signed'(OFFSET[i]));
      assign scaled = (diff * signed'({20'h00000, GAIN[i]})) >>> TAS_GAIN_SHIFT;
      // clip to the 14-bit two's complement range
      assign corr.axis[i] = (scaled > TAS_SAT_MAX) ? TAS_SAT_MAX[13:0] :
                            (scaled < TAS_SAT_MIN) ? TAS_SAT_MIN[13:0] : scaled[13:0];
      // magnitude of the stored sample
      assign mag = sample.axis[i][13] ? 15'(-signed'({sample.axis[i][13], sample.axis[i]}))
                                      : {1'b0, sample.axis[i]};
      assign hit[i] = (mag > TAS_TILT_LIMIT);
   end

   // ------------------------------------------------------------
   // power sequencing
   // ------------------------------------------------------------
   tas_pwr_type pwr, next_pwr;
   logic en_q, next_en_q;
   logic [TAS_CNT_W-1:0] cnt, next_cnt;
   logic ready, next_ready;
   logic next_sensing_on;
   tas_axes_type next_raw_hold, next_sample;
   tas_tilt_type next_tilt;

   always_comb begin
      next_pwr = pwr;
      next_en_q = en;
      next_cnt = cnt;
      next_ready = ready;
      next_raw_hold = raw_hold;
      next_sample = sample;
      next_sensing_on = en;
      next_tilt.oe = {TAS_AXES{en}};
      next_tilt.level = (pwr == TAS_PWR_STANDBY) ? hit : 3'b000;
      unique case (pwr)
         TAS_PWR_OFF: begin
            if (en && !en_q) begin
               next_raw_hold = raw_accel;
               next_cnt = TAS_CNT_W'(CONV_CYCLES - 1);
               next_pwr = TAS_PWR_ACTIVE;
            end
         end
         TAS_PWR_ACTIVE: begin
            if (cnt == '0) begin
               next_sample = corr;
               next_ready = 1'b1;
               next_pwr = TAS_PWR_STANDBY;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         TAS_PWR_STANDBY: begin
         end
         default: next_pwr = TAS_PWR_OFF;
      endcase
      if (!en) begin
         next_pwr = TAS_PWR_OFF;
         next_ready = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr <= TAS_PWR_OFF;
         en_q <= 1'b1;
         cnt <= '0;
         ready <= 1'b0;
         raw_hold <= '0;
         sample <= '0;
         sensing_on <= 1'b0;
         tilt <= '0;
      end else begin
         pwr <= next_pwr;
         en_q <= next_en_q;
         cnt <= next_cnt;
         ready <= next_ready;
         raw_hold <= next_raw_hold;
         sample <= next_sample;
         sensing_on <= next_sensing_on;
         tilt <= next_tilt;
      end
   end

   // ------------------------------------------------------------
   // register read mux
   // ------------------------------------------------------------
   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic rdy,
                                           input tas_axes_type s);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         TAS_REG_STATUS: v = {4'h0, rdy, {3{rdy}}};
         TAS_REG_X_MSB: v = s.axis[0][13:6];
         TAS_REG_X_LSB: v = {s.axis[0][5:0], 2'b00};
         TAS_REG_Y_MSB: v = s.axis[1][13:6];
         TAS_REG_Y_LSB: v = {s.axis[1][5:0], 2'b00};
         TAS_REG_Z_MSB: v = s.axis[2][13:6];
         TAS_REG_Z_LSB: v = {s.axis[2][5:0], 2'b00};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // serial slave
   // ------------------------------------------------------------
   tas_i2c_type ist, next_ist;
   logic scl_q, sda_q;
   logic [7:0] shift, next_shift;
   logic [7:0] ptr, next_ptr;
   logic [2:0] bitcnt, next_bitcnt;
   logic rw, next_rw;
   logic next_sda_oe;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] byte_in;
   logic [7:0] rd_byte;

   assign scl_rise = scl_in && !scl_q;
   assign scl_fall = !scl_in && scl_q;
   assign start_c = scl_in && scl_q && sda_q && !sda_in;
   assign stop_c = scl_in && scl_q && !sda_q && sda_in;
   assign byte_in = {shift[6:0], sda_in};
   assign rd_byte = reg_read(ptr, ready, sample);

   always_comb begin
      next_ist = ist;
      next_shift = shift;
      next_ptr = ptr;
      next_bitcnt = bitcnt;
      next_rw = rw;
      next_sda_oe = sda_oe;
      unique case (ist)
         TAS_I2C_IDLE: next_sda_oe = 1'b0;
         TAS_I2C_ADDR, TAS_I2C_PTR: begin
            if (scl_rise) begin
               next_shift = byte_in;
               next_bitcnt = bitcnt + 1'b1;
               if (bitcnt == 3'd7 && ist == TAS_I2C_PTR) begin
                  next_ptr = byte_in;
                  next_ist = TAS_I2C_PTR_ACK;
               end else if (bitcnt == 3'd7) begin
                  next_rw = byte_in[0];
                  next_ist = (byte_in[7:1] == TAS_SLAVE_ADDR) ? TAS_I2C_ADDR_ACK
                                                              : TAS_I2C_IDLE;
               end
            end
         end
         TAS_I2C_ADDR_ACK, TAS_I2C_PTR_ACK: begin
            if (scl_fall && !sda_oe) begin
               next_sda_oe = 1'b1; // pull low only
            end else if (scl_fall) begin
               next_sda_oe = 1'b0;
               next_bitcnt = 3'd0;
               if (ist == TAS_I2C_PTR_ACK) begin
                  next_ist = TAS_I2C_IDLE;
               end else if (rw) begin
                  next_shift = rd_byte;
                  next_sda_oe = !rd_byte[7];
                  next_ist = TAS_I2C_TX;
               end else begin
                  next_ist = TAS_I2C_PTR;
               end
            end
         end
         TAS_I2C_TX: begin
            if (scl_rise) begin
               next_shift = {shift[6:0], 1'b0};
               next_bitcnt = bitcnt + 1'b1;
            end else if (scl_fall && bitcnt == 3'd0) begin
               next_sda_oe = 1'b0;
               next_ptr = ptr + 1'b1;
               next_ist = TAS_I2C_TX_ACK;
            end else if (scl_fall) begin
               next_sda_oe = !shift[7];
            end
         end
         TAS_I2C_TX_ACK: begin
            if (scl_rise) begin
               next_ist = sda_in ? TAS_I2C_IDLE : TAS_I2C_TX_NEXT;
            end
         end
         TAS_I2C_TX_NEXT: begin
            if (scl_fall) begin
               next_shift = rd_byte;
               next_sda_oe = !rd_byte[7];
               next_bitcnt = 3'd0;
               next_ist = TAS_I2C_TX;
            end
         end
      endcase
      if (start_c) begin
         next_ist = TAS_I2C_ADDR;
         next_bitcnt = 3'd0;
         next_sda_oe = 1'b0;
      end
      if (stop_c || !en) begin
         next_ist = TAS_I2C_IDLE;
         next_sda_oe = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ist <= TAS_I2C_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shift <= 8'h00;
         ptr <= 8'h00;
         bitcnt <= 3'd0;
         rw <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         ist <= next_ist;
         scl_q <= scl_in;
         sda_q <= sda_in;
         shift <= next_shift;
         ptr <= next_ptr;
         bitcnt <= next_bitcnt;
         rw <= next_rw;
         sda_oe <= next_sda_oe;
         sda_out <= 1'b0;
      end
   end

endmodule

// *** testbench/tas_readout_props.sv ***
// checker for the tilt sensor readout ports
`timescale 1ns/1ps
module tas_readout_props #(
   parameter int CONV_CYCLES = tas_pkg::TAS_CONV_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // power and samples
   input wire logic en,
   input wire logic sensing_on,
   input wire tas_pkg::tas_axes_type raw_accel,
   // tilt pins
   input wire tas_pkg::tas_tilt_type tilt,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe
);
   import tas_pkg::*;
   logic en_d;
   logic [2:0] hit;
   logic [2:0] next_hit;
   int cnt;
   int next_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // expected tilt bits from the samples captured at enable rise
   always_comb begin
      next_cnt = (en && !en_d) ? 0 : cnt + 1;
      next_hit = hit;
      for (int i = 0; i < 3; i++) begin
         if (en && !en_d) begin
            next_hit[i] = ($signed(raw_accel.axis[i]) > 688) ||
                          ($signed(raw_accel.axis[i]) < -688);
         end
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         en_d <= 1'b1;
         cnt <= 0;
         hit <= '0;
      end else begin
         en_d <= en;
         cnt <= next_cnt;
         hit <= next_hit;
      end
   end
   a_sda_low_only: assert property (sda_oe |-> !sda_out)
      else $error("serial data driven high");
   a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("serial data changed while clock high");
   a_oe_follow: assert property (tilt.oe == {3{$past(en)}})
      else $error("tilt drive does not follow enable");
   a_power_follow: assert property (sensing_on == $past(en))
      else $error("sensing power does not follow enable");
   a_off_quiet: assert property (!en |=> (tilt.oe == 3'b000 && !sda_oe))
      else $error("outputs active while disabled");
   a_off_level: assert property (!en [*2] |=> (tilt.level == 3'b000))
      else $error("tilt level held while disabled");
   a_conv_quiet: assert property ($rose(en) |=> (tilt.level == 3'b000) [*8])
      else $error("tilt level raised during conversion");
   a_tilt_level: assert property ((cnt >= CONV_CYCLES + 2 && en) |-> tilt.level == hit)
      else $error("tilt level wrong after conversion");
   a_ack_powered: assert property (sda_oe |-> sensing_on)
      else $error("serial answer while powered down");
   c_conv: cover property ($rose(en));
   c_ack: cover property ($rose(sda_oe));
   c_tilt: cover property (tilt.level != 3'b000);
endmodule
bind tas_sensor_readout tas_readout_props #(.CONV_CYCLES(CONV_CYCLES)) u_tas_readout_props (
   .core_clk(core_clk), .resetn(resetn), .en(en), .sensing_on(sensing_on),
   .raw_accel(raw_accel), .tilt(tilt), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe));

// *** testbench/tas_master_model.sv ***
// serial bus master model: push-pull clock, open-drain data with pull-up
`timescale 1ns/1ps
module tas_master_model (
   // clock
   input wire logic core_clk,
   // bus
   input wire logic dev_sda_oe,
   output logic scl,
   output logic sda
);
   logic m_low = 1'b0;
   initial scl = 1'b1; // push-pull clock drive
   assign sda = !(m_low || dev_sda_oe); // pull-up when released
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic start();
      m_low = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(10);
      m_low = 1'b1;
      tick(10);
      scl = 1'b0;
   endtask
   task automatic stop();
      m_low = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(10);
      m_low = 1'b0;
      tick(10);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
      logic [8:0] b;
      b = {tx, ack_in};
      for (int i = 8; i >= 0; i--) begin
         m_low = !b[i];
         tick(15);
         scl = 1'b1;
         tick(20);
         b[i] = sda;
         scl = 1'b0;
         tick(5);
      end
      rx = b[8:1];
      ack_out = b[0];
   endtask
endmodule

// *** testbench/tas_sensor_readout_bench.sv ***
// testbench for the tilt sensor readout
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) fail_msg(n, e, s); end
module tas_sensor_readout_bench;
   import tas_pkg::*;
   localparam int CONV = 8;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic en = 1'b0;
   logic sensing_on;
   logic sda_out;
   logic sda_oe;
   logic scl;
   logic sda;
   tas_axes_type raw_accel = '0;
   tas_tilt_type tilt;
   int n_fail = 0;
   int checks = 0;
   always #25 core_clk = ~core_clk;
   tas_sensor_readout #(.CONV_CYCLES(CONV)) u_tas_sensor_readout (.core_clk(core_clk),
      .resetn(resetn), .en(en), .sensing_on(sensing_on), .raw_accel(raw_accel),
      .tilt(tilt), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   tas_master_model u_tas_master_model (.core_clk(core_clk), .dev_sda_oe(sda_oe),
      .scl(scl), .sda(sda));
   task automatic fail_msg(input string n, input logic [15:0] e, input logic [15:0] s);
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
   endtask
   task automatic convert(input logic [13:0] x, y, z, input logic [2:0] exp_hit);
      en = 1'b0;
      raw_accel.axis[0] = x;
      raw_accel.axis[1] = y;
      raw_accel.axis[2] = z;
      @(negedge core_clk);
      en = 1'b1;
      repeat (3) @(negedge core_clk);
      `CHK("tilt oe", 3'b111, tilt.oe)
      `CHK("power", 1'b1, sensing_on)
      `CHK("busy level", 3'b000, tilt.level)
      repeat (CONV) @(negedge core_clk);
      `CHK("tilt level", exp_hit, tilt.level)
   endtask
   task automatic test_tilt();
      convert(14'h02B0, 14'h02B1, 14'h3D4F, 3'b110);
      convert(14'h2000, 14'h3D50, 14'h02B0, 3'b001);
      $display("test tilt done");
   endtask
   task automatic test_read();
      logic [7:0] exp [7];
      logic [7:0] rx;
      logic a;
      convert(14'h3D50, 14'h1FFF, 14'h0000, 3'b010);
      exp[0] = 8'h0F;
      for (int i = 0; i < 3; i++) begin
         exp[2 * i + 1] = raw_accel.axis[i][13:6];
         exp[2 * i + 2] = {raw_accel.axis[i][5:0], 2'b00};
      end
      u_tas_master_model.start();
      u_tas_master_model.xfer({TAS_SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
      `CHK("addr ack", 1'b0, a)
      `CHK("sda level", 1'b0, sda_out)
      u_tas_master_model.xfer(TAS_REG_STATUS, 1'b1, rx, a);
      `CHK("ptr ack", 1'b0, a)
      u_tas_master_model.start();
      u_tas_master_model.xfer({TAS_SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
      `CHK("read ack", 1'b0, a)
      for (int i = 0; i < 7; i++) begin
         u_tas_master_model.xfer(8'hFF, i == 6, rx, a);
         `CHK("read byte", exp[i], rx)
      end
      u_tas_master_model.stop();
      $display("test read done");
   endtask
   task automatic test_addr();
      logic [7:0] rx;
      logic a;
      u_tas_master_model.start();
      u_tas_master_model.xfer({TAS_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, rx, a);
      `CHK("foreign addr", 1'b1, a)
      u_tas_master_model.stop();
      $display("test addr done");
   endtask
   task automatic test_off();
      logic [7:0] rx;
      logic a;
      en = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("power off", 1'b0, sensing_on)
      `CHK("off oe", 3'b000, tilt.oe)
      `CHK("off level", 3'b000, tilt.level)
      u_tas_master_model.start();
      u_tas_master_model.xfer({TAS_SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
      `CHK("off ack", 1'b1, a)
      u_tas_master_model.stop();
      $display("test off done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (5) @(negedge core_clk);
      resetn = 1'b1;
      repeat (3) @(negedge core_clk);
      test_tilt();
      test_read();
      test_addr();
      test_off();
      complete_run();
   end
endmodule
